/* pkg/gpw_pkg.sv */
// Summary of operation
// - Pins packed into two data registers, 7:5 reserved
// - Input read returns pin level, polarity applied
// - Writes to input data bits are ignored
// - Output drives last written bit, polarity applied
// - Output read returns last written value
// - Control bits: 0 direction, 1 polarity, 7 driver
// - Direction 0 output; polarity 1 inverts
// - Driver type selects open-drain or push-pull
// - Polarity inverts alternate path except edge/display
// - Output ports never set wake status
// - Twelve wake pins set status on polarity edge
// - Event needs status, pin enable, global enable
// - Wake status bits clear on write one
// - Group a and group b status/enable pairs
// - Either-edge pins flag both transitions
// - Either-edge ignores control bits except read polarity
// - Either-edge pin event needs enable and selection
// - Either-edge flags gathered in misc status, W1C
// - Either-edge flags update regardless of enables
// - Shutdown pin has no wake capability
package gpw_pkg;
    localparam int NUM_PINS  = 13;
    localparam int NUM_WAKE  = 12;
    localparam int NUM_EDGE  = 2;
    localparam int NUM_DISP  = 4;
    localparam int GRP_A_W   = 8;
    localparam int GRP_B_W   = 4;
    localparam int BANK_W    = 8;
    localparam int BANK2_W   = 5;
    localparam int IDX_W     = 8;
    localparam int IDX_LSB   = 2;

    // Pin numbering: 0 shutdown, 1..8 group a, 9..12 group b
    localparam int PIN_GRP_A = 1;
    localparam int PIN_GRP_B = 9;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_DATA_FIRST  = 8'h15;
    localparam logic [IDX_W-1:0] IDX_DATA_SECOND = 8'h16;
    localparam logic [IDX_W-1:0] IDX_CTRL_BASE   = 8'h20;
    localparam logic [IDX_W-1:0] IDX_STS_A       = 8'h30;
    localparam logic [IDX_W-1:0] IDX_STS_B       = 8'h31;
    localparam logic [IDX_W-1:0] IDX_EN_A        = 8'h32;
    localparam logic [IDX_W-1:0] IDX_EN_B        = 8'h33;
    localparam logic [IDX_W-1:0] IDX_GLOBAL_EN   = 8'h34;
    localparam logic [IDX_W-1:0] IDX_MISC_STS    = 8'h35;
    localparam logic [IDX_W-1:0] IDX_ALT_SEL     = 8'h36;

    localparam int CTRL_DIR_BIT = 0;
    localparam int CTRL_POL_BIT = 1;
    localparam int CTRL_DRV_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h01;

    localparam int ALT_EDGE_LSB = 0;
    localparam int ALT_DISP_LSB = 2;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

/* src/gpw_pin_sync.sv */
`timescale 1ns/1ps
module gpw_pin_sync (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic pinRaw,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic stage1_q;
    logic stage2_q;
    logic prev_q;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
            prev_q   <= 1'b0;
        end else begin
            stage1_q <= pinRaw;
            stage2_q <= stage1_q;
            prev_q   <= stage2_q;
        end
    end

    assign level = stage2_q;
    assign rise  = stage2_q & ~prev_q;
    assign fall  = ~stage2_q & prev_q;
endmodule

/* src/gpw_port.sv */
`timescale 1ns/1ps
module gpw_port (
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic [31:0]                        hrdata,
    input  wire logic [gpw_pkg::NUM_PINS-1:0]  pinIn,
    output logic [gpw_pkg::NUM_PINS-1:0]       pinOut,
    output logic [gpw_pkg::NUM_PINS-1:0]       pinOe,
    output logic [gpw_pkg::NUM_PINS-1:0]       pinAltIn,
    output logic                               powerManagementEvent
);
    localparam int NP = gpw_pkg::NUM_PINS;
    localparam int NW = gpw_pkg::NUM_WAKE;
    localparam int NE = gpw_pkg::NUM_EDGE;
    localparam int ND = gpw_pkg::NUM_DISP;
    localparam int IW = gpw_pkg::IDX_W;

    logic [7:0]      ctrl_q [NP];
    logic [NP-1:0]   data_q;
    logic [NW-1:0]   wakeSts_q;
    logic [NW-1:0]   wakeEn_q;
    logic            globalEn_q;
    logic [NE-1:0]   miscSts_q;
    logic [NE+ND-1:0] altSel_q;
    logic            wrPend_q;
    logic [IW-1:0]   wrIdx_q;
    logic [31:0]     hrdata_q;
    logic [NP-1:0]   pinOut_q;
    logic [NP-1:0]   pinOe_q;
    logic [NP-1:0]   pinAlt_q;
    logic            pme_q;

    logic [NP-1:0]   pinLvl;
    logic [NP-1:0]   pinRise;
    logic [NP-1:0]   pinFall;
    logic [NP-1:0]   dirIn;
    logic [NP-1:0]   pol;
    logic [NP-1:0]   pushPull;
    logic [NP-1:0]   edgeSel;
    logic [NP-1:0]   dispSel;
    logic [NP-1:0]   isOut;
    logic [NP-1:0]   readBits;
    logic [NP-1:0]   driveVal;
    logic [NW-1:0]   wakeEvt;
    logic [NE-1:0]   anyEdge;
    logic [NW-1:0]   wakeClr;
    logic [NE-1:0]   miscClr;
    logic [31:0]     rdMux;
    logic            addrTake;
    logic [IW-1:0]   addrIdx;

    // Synchronisers and edge detectors, one per pin
    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : gen_sync
            gpw_pin_sync u_sync (
                .ref_clk (ref_clk),
                .sys_rst (sys_rst),
                .pinRaw  (pinIn[g]),
                .level   (pinLvl[g]),
                .rise    (pinRise[g]),
                .fall    (pinFall[g])
            );
            assign dirIn[g]    = ctrl_q[g][gpw_pkg::CTRL_DIR_BIT];
            assign pol[g]      = ctrl_q[g][gpw_pkg::CTRL_POL_BIT];
            assign pushPull[g] = ctrl_q[g][gpw_pkg::CTRL_DRV_BIT];
        end
    endgenerate

    // Alternate selections only exist on group b pins: either-edge on the first two, display on all four
    always_comb begin
        edgeSel = '0;
        dispSel = '0;
        for (int i = 0; i < NE; i++) begin
            edgeSel[gpw_pkg::PIN_GRP_B+i] = altSel_q[gpw_pkg::ALT_EDGE_LSB+i];
        end
        for (int i = 0; i < ND; i++) begin
            dispSel[gpw_pkg::PIN_GRP_B+i] = altSel_q[gpw_pkg::ALT_DISP_LSB+i];
        end
    end

    // Either-edge and display functions take the pin away from the port logic
    assign isOut    = ~dirIn & ~edgeSel & ~dispSel;
    assign driveVal = data_q ^ pol;
    assign readBits = (isOut & data_q) | (~isOut & (pinLvl ^ pol));

    // Wake events on group pins; index 0 of the wake vectors is pin 1
    always_comb begin
        wakeEvt = '0;
        anyEdge = '0;
        for (int i = 0; i < NW; i++) begin
            if (edgeSel[i+1]) begin
                wakeEvt[i] = pinRise[i+1] | pinFall[i+1];
            end else if (dirIn[i+1]) begin
                wakeEvt[i] = pol[i+1] ? pinFall[i+1] : pinRise[i+1];
            end else begin
                wakeEvt[i] = 1'b0;
            end
        end
        for (int i = 0; i < NE; i++) begin
            anyEdge[i] = pinRise[gpw_pkg::PIN_GRP_B+i] | pinFall[gpw_pkg::PIN_GRP_B+i];
        end
    end

    // Bus slave: zero wait states, always OKAY
    assign addrTake  = hsel & hready & (htrans == gpw_pkg::HTRANS_NONSEQ);
    assign addrIdx   = haddr[gpw_pkg::IDX_LSB +: IW];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    always_comb begin
        rdMux = '0;
        if (addrIdx == gpw_pkg::IDX_DATA_FIRST) begin
            rdMux[gpw_pkg::BANK_W-1:0] = readBits[gpw_pkg::BANK_W-1:0];
        end else if (addrIdx == gpw_pkg::IDX_DATA_SECOND) begin
            rdMux[gpw_pkg::BANK2_W-1:0] = readBits[NP-1:gpw_pkg::BANK_W];
        end else if (addrIdx == gpw_pkg::IDX_STS_A) begin
            rdMux[gpw_pkg::GRP_A_W-1:0] = wakeSts_q[gpw_pkg::GRP_A_W-1:0];
        end else if (addrIdx == gpw_pkg::IDX_STS_B) begin
            rdMux[gpw_pkg::GRP_B_W-1:0] = wakeSts_q[NW-1:gpw_pkg::GRP_A_W];
        end else if (addrIdx == gpw_pkg::IDX_EN_A) begin
            rdMux[gpw_pkg::GRP_A_W-1:0] = wakeEn_q[gpw_pkg::GRP_A_W-1:0];
        end else if (addrIdx == gpw_pkg::IDX_EN_B) begin
            rdMux[gpw_pkg::GRP_B_W-1:0] = wakeEn_q[NW-1:gpw_pkg::GRP_A_W];
        end else if (addrIdx == gpw_pkg::IDX_GLOBAL_EN) begin
            rdMux[0] = globalEn_q;
        end else if (addrIdx == gpw_pkg::IDX_MISC_STS) begin
            rdMux[NE-1:0] = miscSts_q;
        end else if (addrIdx == gpw_pkg::IDX_ALT_SEL) begin
            rdMux[NE+ND-1:0] = altSel_q;
        end else begin
            for (int i = 0; i < NP; i++) begin
                if (addrIdx == gpw_pkg::IDX_CTRL_BASE + IW'(i)) begin
                    rdMux[7:0] = ctrl_q[i];
                end
            end
        end
    end

    // Read data is latched at the address phase, so the pin is sampled then
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata_q <= '0;
        end else if (addrTake && !hwrite) begin
            hrdata_q <= rdMux;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPend_q <= 1'b0;
            wrIdx_q  <= '0;
        end else begin
            wrPend_q <= addrTake & hwrite;
            if (addrTake) begin
                wrIdx_q <= addrIdx;
            end
        end
    end

    // Control registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NP; i++) begin
                ctrl_q[i] <= gpw_pkg::CTRL_RESET;
            end
        end else if (wrPend_q) begin
            for (int i = 0; i < NP; i++) begin
                if (wrIdx_q == gpw_pkg::IDX_CTRL_BASE + IW'(i)) begin
                    ctrl_q[i] <= hwdata[7:0];
                end
            end
        end
    end

    // Data bits: only ports currently driving accept writes
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_q <= '0;
        end else if (wrPend_q) begin
            // Split loops keep every hwdata index in range
            for (int i = 0; i < gpw_pkg::BANK_W; i++) begin
                if (isOut[i] && wrIdx_q == gpw_pkg::IDX_DATA_FIRST) begin
                    data_q[i] <= hwdata[i];
                end
            end
            for (int i = gpw_pkg::BANK_W; i < NP; i++) begin
                if (isOut[i] && wrIdx_q == gpw_pkg::IDX_DATA_SECOND) begin
                    data_q[i] <= hwdata[i-gpw_pkg::BANK_W];
                end
            end
        end
    end

    // Enables and alternate selection
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wakeEn_q   <= '0;
            globalEn_q <= 1'b0;
            altSel_q   <= '0;
        end else if (wrPend_q) begin
            if (wrIdx_q == gpw_pkg::IDX_EN_A) begin
                wakeEn_q[gpw_pkg::GRP_A_W-1:0] <= hwdata[gpw_pkg::GRP_A_W-1:0];
            end
            if (wrIdx_q == gpw_pkg::IDX_EN_B) begin
                wakeEn_q[NW-1:gpw_pkg::GRP_A_W] <= hwdata[gpw_pkg::GRP_B_W-1:0];
            end
            if (wrIdx_q == gpw_pkg::IDX_GLOBAL_EN) begin
                globalEn_q <= hwdata[0];
            end
            if (wrIdx_q == gpw_pkg::IDX_ALT_SEL) begin
                altSel_q <= hwdata[NE+ND-1:0];
            end
        end
    end

    // Write-one-to-clear masks
    always_comb begin
        wakeClr = '0;
        miscClr = '0;
        if (wrPend_q && wrIdx_q == gpw_pkg::IDX_STS_A) begin
            wakeClr[gpw_pkg::GRP_A_W-1:0] = hwdata[gpw_pkg::GRP_A_W-1:0];
        end
        if (wrPend_q && wrIdx_q == gpw_pkg::IDX_STS_B) begin
            wakeClr[NW-1:gpw_pkg::GRP_A_W] = hwdata[gpw_pkg::GRP_B_W-1:0];
        end
        if (wrPend_q && wrIdx_q == gpw_pkg::IDX_MISC_STS) begin
            miscClr = hwdata[NE-1:0];
        end
    end

    // Status flags set regardless of enables; a new event beats a clear
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wakeSts_q <= '0;
            miscSts_q <= '0;
        end else begin
            wakeSts_q <= (wakeSts_q & ~wakeClr) | wakeEvt;
            miscSts_q <= (miscSts_q & ~miscClr) | anyEdge;
        end
    end

    // Event request; the shutdown pin has no status bit at all
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pme_q <= 1'b0;
        end else begin
            pme_q <= globalEn_q & (|(wakeSts_q & wakeEn_q));
        end
    end
    assign powerManagementEvent = pme_q;

    // Pin drivers; open-drain only pulls low
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinOut_q <= '0;
            pinOe_q  <= '0;
            pinAlt_q <= '0;
        end else begin
            for (int i = 0; i < NP; i++) begin
                pinOut_q[i] <= pushPull[i] & driveVal[i];
                pinOe_q[i]  <= isOut[i] & (pushPull[i] | ~driveVal[i]);
                pinAlt_q[i] <= (edgeSel[i] | dispSel[i]) ? pinLvl[i]
                                                         : pinLvl[i] ^ pol[i];
            end
        end
    end
    assign pinOut   = pinOut_q;
    assign pinOe    = pinOe_q;
    assign pinAltIn = pinAlt_q;
endmodule

/* sim/gpw_port_chk.sv */
`timescale 1ns/1ps
module gpw_port_chk (
    input wire logic                         ref_clk,
    input wire logic                         sys_rst,
    input wire logic                         hsel,
    input wire logic [31:0]                  haddr,
    input wire logic [1:0]                   htrans,
    input wire logic                         hwrite,
    input wire logic [31:0]                  hwdata,
    input wire logic                         hready,
    input wire logic [31:0]                  hrdata,
    input wire logic [gpw_pkg::NUM_PINS-1:0] pinOut,
    input wire logic [gpw_pkg::NUM_PINS-1:0] pinOe,
    input wire logic                         powerManagementEvent
);
    logic        aphQ;
    logic        wrQ;
    logic        glbQ;
    logic        rdTake;
    logic [7:0]  idxQ;
    logic [5:0]  altQ;
    logic [11:0] enQ;
    logic [12:0] dirQ, polQ, drvQ, datQ, altM, ppM, odM;

    // Shadow of the pin setup, rebuilt from bus traffic alone
    assign altM = {altQ[5:4], altQ[3:2] | altQ[1:0], 9'h0};
    assign ppM = ~dirQ & drvQ & ~altM;
    assign odM = ~dirQ & ~drvQ & ~altM;
    assign rdTake = hsel && hready && htrans == gpw_pkg::HTRANS_NONSEQ && !hwrite;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {aphQ, wrQ, idxQ} <= '0;
            {polQ, drvQ, datQ, altQ, enQ, glbQ} <= '0;
            dirQ <= 13'h1FFF;
        end else begin
            aphQ <= hsel && hready && htrans == gpw_pkg::HTRANS_NONSEQ;
            wrQ <= hwrite;
            idxQ <= haddr[9:2];
            if (aphQ && wrQ) begin
                for (int i = 0; i < 13; i++) begin
                    if (idxQ == gpw_pkg::IDX_CTRL_BASE + 8'(i)) begin
                        dirQ[i] <= hwdata[0];
                        polQ[i] <= hwdata[1];
                        drvQ[i] <= hwdata[7];
                    end
                    if (!dirQ[i] && !altM[i] && idxQ == gpw_pkg::IDX_DATA_FIRST + 8'(i / 8))
                        datQ[i] <= hwdata[i % 8];
                end
                if (idxQ == gpw_pkg::IDX_EN_A)
                    enQ[7:0] <= hwdata[7:0];
                if (idxQ == gpw_pkg::IDX_EN_B)
                    enQ[11:8] <= hwdata[3:0];
                if (idxQ == gpw_pkg::IDX_GLOBAL_EN)
                    glbQ <= hwdata[0];
                if (idxQ == gpw_pkg::IDX_ALT_SEL)
                    altQ <= hwdata[5:0];
            end
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    // Pins follow the registers one edge late, hence the past shadow
    AST_IN_NOT_DRIVEN: assert property (
        (pinOe & ($past(dirQ) | $past(altM))) == 13'h0) else $error("Input pin driven");
    AST_PP_ENABLED: assert property (
        (pinOe & $past(ppM)) == $past(ppM)) else $error("Push-pull pin not driven");
    AST_PP_VALUE: assert property (
        ((pinOut ^ $past(datQ) ^ $past(polQ)) & $past(ppM)) == 13'h0)
        else $error("Push-pull value wrong");
    AST_OD_LOW: assert property (
        (pinOut & $past(odM)) == 13'h0) else $error("Open-drain pin drives high");
    AST_OD_RELEASE: assert property (
        ((pinOe ^ ~($past(datQ) ^ $past(polQ))) & $past(odM)) == 13'h0)
        else $error("Open-drain enable wrong");
    AST_EVT_GLOBAL: assert property (
        !$past(glbQ) |-> !powerManagementEvent) else $error("Event with global off");
    AST_EVT_ENABLE: assert property (
        $past(enQ) == 12'h0 |-> !powerManagementEvent) else $error("Event with no enable");
    AST_RD_HOLD: assert property (
        !rdTake |=> $stable(hrdata)) else $error("Read data moved without a read");

    cover property (powerManagementEvent);
    cover property (|$past(odM));
    cover property (rdTake && haddr[9:2] == gpw_pkg::IDX_DATA_SECOND);
endmodule

bind gpw_port gpw_port_chk gpw_port_chk_inst (
    .ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
    .pinOut, .pinOe, .powerManagementEvent
);

/* sim/gpw_port_tb_top.sv */
`timescale 1ns/1ps
module gpw_port_tb_top;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [12:0] pinIn = 13'h0;
    logic [31:0] hrdata, rdV;
    logic        hreadyout, hresp, power_management_event, glb;
    logic [12:0] pinOut, pinOe, pinAltIn, p0, p1, dir, pol, drv, altM, em, sts, v;
    logic [11:0] en;
    logic [1:0]  edg;
    logic [3:0]  dsp;
    int          num_errors = 0;
    int          checks_done = 0;
    int          seed = 2;

    always #50 ref_clk = ~ref_clk;

    gpw_port gpw_port_inst (
        .ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pinIn, .pinOut, .pinOe,
        .pinAltIn, .powerManagementEvent(power_management_event)
    );

    task automatic end_of_test();
        if (num_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkP(input logic [12:0] got, input logic [12:0] exp);
        chk({19'h0, got}, {19'h0, exp});
    endtask

    task automatic hwait();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            num_errors++;
            end_of_test();
        end
    endtask

    task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        htrans <= gpw_pkg::HTRANS_NONSEQ;
        hwait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        hwait();
        rdV = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        bus(idx, 1'b0, 32'h0);
        chk(rdV, exp);
    endtask

    task automatic ctlAll();
        for (int i = 0; i < 13; i++)
            bus(gpw_pkg::IDX_CTRL_BASE + 8'(i), 1'b1, {24'h0, drv[i], 5'h0, pol[i], dir[i]});
    endtask

    task automatic chkWake();
        rd(gpw_pkg::IDX_STS_A, {24'h0, sts[8:1]});
        rd(gpw_pkg::IDX_STS_B, {28'h0, sts[12:9]});
        chkP({12'h0, power_management_event}, {12'h0, glb & (|(sts[12:1] & en))});
    endtask

    function automatic logic [12:0] wakeExp(input logic [12:0] a, input logic [12:0] b);
        return (em & (a ^ b)) | (~em & dir & (a ^ b) & (b ^ pol) & 13'h1FFE);
    endfunction

    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(gpw_pkg::IDX_CTRL_BASE, {24'h0, gpw_pkg::CTRL_RESET});
        bus(8'h3F, 1'b1, 32'hFFFF_FFFF);
        rd(8'h3F, 32'h0);
        bus(gpw_pkg::IDX_ALT_SEL, 1'b1, 32'h0);
        for (int it = 0; it < 4; it++) begin
            pol = 13'($random(seed));
            drv = it == 0 ? 13'h0 : 13'($random(seed));
            dir = 13'h0;
            ctlAll();
            v = 13'($random(seed));
            bus(gpw_pkg::IDX_DATA_FIRST, 1'b1, {24'h0, v[7:0]});
            bus(gpw_pkg::IDX_DATA_SECOND, 1'b1, {27'h0, v[12:8]});
            pinIn <= ~v;
            repeat (2) @(posedge ref_clk);
            chkP(pinOut, (v ^ pol) & drv);
            chkP(pinOe, drv | ~(v ^ pol));
            rd(gpw_pkg::IDX_DATA_FIRST, {24'h0, v[7:0]});
            rd(gpw_pkg::IDX_CTRL_BASE + 8'h5, {24'h0, drv[5], 5'h0, pol[5], 1'b0});
            dir = 13'h1FFF;
            ctlAll();
            bus(gpw_pkg::IDX_DATA_FIRST, 1'b1, {24'h0, ~v[7:0]});
            bus(gpw_pkg::IDX_DATA_SECOND, 1'b1, {27'h0, ~v[12:8]});
            dir = 13'h0;
            ctlAll();
            rd(gpw_pkg::IDX_DATA_SECOND, {27'h0, v[12:8]});
        end
        for (int it = 0; it < 8; it++) begin
            p0 = 13'($random(seed));
            p1 = it == 0 ? ~p0 : 13'($random(seed));
            pol = 13'($random(seed));
            drv = 13'($random(seed));
            dir = it == 0 ? 13'h1FFF : 13'($random(seed));
            edg = 2'($random(seed));
            dsp = it == 0 ? 4'h0 : 4'($random(seed));
            en = it == 0 ? 12'hFFF : 12'($random(seed));
            glb = it == 0 ? 1'b1 : 1'($random(seed));
            em = {2'h0, edg, 9'h0};
            // Display pins drop polarity on the alternate path only
            altM = em | {dsp, 9'h0};
            pinIn <= p0;
            // Alternate off while data is written, so every output latches it
            bus(gpw_pkg::IDX_ALT_SEL, 1'b1, 32'h0);
            ctlAll();
            bus(gpw_pkg::IDX_DATA_FIRST, 1'b1, 32'h0);
            bus(gpw_pkg::IDX_DATA_SECOND, 1'b1, 32'h0);
            bus(gpw_pkg::IDX_ALT_SEL, 1'b1, {26'h0, dsp, edg});
            bus(gpw_pkg::IDX_EN_A, 1'b1, {24'h0, en[7:0]});
            bus(gpw_pkg::IDX_EN_B, 1'b1, {28'h0, en[11:8]});
            bus(gpw_pkg::IDX_GLOBAL_EN, 1'b1, {31'h0, glb});
            // Setup changes may flag edges of their own, so clear last
            bus(gpw_pkg::IDX_STS_A, 1'b1, 32'hFF);
            bus(gpw_pkg::IDX_STS_B, 1'b1, 32'hF);
            bus(gpw_pkg::IDX_MISC_STS, 1'b1, 32'h3);
            pinIn <= p1;
            repeat (6) @(posedge ref_clk);
            sts = wakeExp(p0, p1);
            chkWake();
            rd(gpw_pkg::IDX_MISC_STS, {30'h0, p0[10:9] ^ p1[10:9]});
            v = (p1 ^ pol) & (dir | altM);
            rd(gpw_pkg::IDX_DATA_FIRST, {24'h0, v[7:0]});
            rd(gpw_pkg::IDX_DATA_SECOND, {27'h0, v[12:8]});
            chkP(pinAltIn, p1 ^ (pol & ~altM));
            v = 13'($random(seed));
            bus(gpw_pkg::IDX_STS_A, 1'b1, {24'h0, v[8:1]});
            bus(gpw_pkg::IDX_STS_B, 1'b1, {28'h0, v[12:9]});
            sts = sts & ~v;
            chkWake();
        end
        sys_rst <= 1'b1;
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(gpw_pkg::IDX_CTRL_BASE + 8'hC, {24'h0, gpw_pkg::CTRL_RESET});
        chkP(pinOe, 13'h0);
        end_of_test();
    end
endmodule
